// ### inc/pcbhp_cfg.svh
// Constants for the expansion-bus to host-port bridge
`ifndef PCBHP_CFG_SVH
`define PCBHP_CFG_SVH

// Memory window: bus address bits 19..12 select the 4 KB block
`define PCBHP_WIN_HI      19
`define PCBHP_WIN_LO      12
`define PCBHP_WIN_TAG     8'hC7

// Sub-range field: bus address bits 11..8
`define PCBHP_SUB_HI      11
`define PCBHP_SUB_LO      8
`define PCBHP_SUB_ALO     4'h0
`define PCBHP_SUB_AHI     4'h1
`define PCBHP_SUB_CTL     4'h2

// Byte lane select bit of the bus address
`define PCBHP_LANE_BIT    0

// Reset values
`define PCBHP_PTR_RST     32'h0000_0000
`define PCBHP_WORD_RST    16'h0000
`define PCBHP_BYTE_RST    8'h00
`define PCBHP_ADDR_RST    20'h0_0000
`define PCBHP_STB_IDLE    1'b1
`define PCBHP_DACK_RST    1'b0

// Pointer step after a completed data-port word, in bit addresses
`define PCBHP_PTR_STEP    32'h0000_0010

// Register file entries
`define PCBHP_RF_DATA     1'b0
`define PCBHP_RF_CTL      1'b1

`endif

// ### inc/pcbhp_pkg.sv
// Types shared by the bridge and its register store
package pcbhp_pkg;

    // Function select code, packed as {function_select_1, function_select_0}
    typedef enum logic [1:0] {
        PCBHP_FS_ALO  = 2'h0,
        PCBHP_FS_DATA = 2'h1,
        PCBHP_FS_AHI  = 2'h2,
        PCBHP_FS_CTL  = 2'h3
    } pcbhp_fs_e;

    // Access sequencer, Gray coded along idle, active, finish
    typedef enum logic [1:0] {
        PCBHP_ST_IDLE   = 2'h0,
        PCBHP_ST_ACTIVE = 2'h1,
        PCBHP_ST_FINISH = 2'h3
    } pcbhp_state_e;

    // Expansion bus pins as sampled
    typedef struct packed {
        logic [19:0] addr;
        logic        rd_n;
        logic        wr_n;
        logic        dack;
        logic [7:0]  data;
    } pcbhp_bus_s;

    // Host-port control pins
    typedef struct packed {
        logic        cs_n;
        logic        uds_n;
        logic        lds_n;
        logic        rd_n;
        logic        wr_n;
        pcbhp_fs_e   fs;
    } pcbhp_port_s;

    // One register-store write
    typedef struct packed {
        logic        en;
        logic        idx;
        logic [1:0]  be;
        logic [15:0] data;
    } pcbhp_wr_s;

endpackage : pcbhp_pkg

// ### rtl/pcbhp_regfile.sv
// Word store for the data port and control register
`timescale 1ns/1ps
`include "pcbhp_cfg.svh"

module pcbhp_regfile
    import pcbhp_pkg::*;
#(
    parameter int WORD_W = 16
)(
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    input  wire pcbhp_wr_s         wr_i,
    input  wire logic              rd_idx_i,
    output logic [WORD_W-1:0]      rd_data_o,
    output logic [WORD_W-1:0]      ctrl_word_o
);

    logic [WORD_W-1:0] mem_r [2];

    // Byte-enabled writes, one process per entry and byte lane
    for (genvar e = 0; e < 2; e++) begin : g_entry
        for (genvar b = 0; b < WORD_W / 8; b++) begin : g_lane
            always_ff @(posedge mclk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    mem_r[e][b*8 +: 8] <= `PCBHP_BYTE_RST;
                end else if (wr_i.en && wr_i.be[b]
                             && wr_i.idx == 1'(e)) begin
                    mem_r[e][b*8 +: 8] <= wr_i.data[b*8 +: 8];
                end
            end
        end
    end

    // Registered read port
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= `PCBHP_WORD_RST;
        end else begin
            rd_data_o <= mem_r[rd_idx_i];
        end
    end

    // Control word straight from its storage flops
    assign ctrl_word_o = mem_r[`PCBHP_RF_CTL];

endmodule : pcbhp_regfile

// ### rtl/pcbhp_bridge.sv
// Expansion-bus memory window to 16-bit host port bridge
`timescale 1ns/1ps
`include "pcbhp_cfg.svh"

// Functional notes
// (RULE_01) Two 16-bit halves form 32-bit pointer
// (RULE_02) 16-bit data port moves local memory data
// (RULE_03) Control register steers processor functions
// (RULE_04) Byte strobes come from address bit zero
// (RULE_05) Bus byte feeds both port data halves
// (RULE_06) Buffer direction follows read; enabled by select
// (RULE_07) Port strobes are buffered bus memory strobes
// (RULE_08) Decoder sees A19-A8, both strobes, DMA acknowledge
// (RULE_09) Select in window, strobe low, acknowledge high
// (RULE_10) Acknowledge low blocks select during refresh
// (RULE_11) Sub-range drives the two function selects
// (RULE_12) Read/write by strobes; lane by byte strobe
// (RULE_13) No operation while chip select high
// (RULE_14) Data port owns the largest sub-range
// (RULE_15) Fixed sub-ranges map to function codes
module pcbhp_bridge
    import pcbhp_pkg::*;
#(
    parameter logic [31:0] PTR_STEP = `PCBHP_PTR_STEP
)(
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic [19:0] bus_addr_i,
    input  wire logic        bus_mem_read_n_i,
    input  wire logic        bus_mem_write_n_i,
    input  wire logic        bus_dack_i,
    input  wire logic [7:0]  bus_data_i,
    output logic      [7:0]  bus_data_o,
    output logic             bus_data_oe_o,
    output logic             port_chip_select_n_o,
    output logic             function_select_0_o,
    output logic             function_select_1_o,
    output logic             upper_byte_strobe_n_o,
    output logic             lower_byte_strobe_n_o,
    output logic             port_read_strobe_n_o,
    output logic             port_write_strobe_n_o,
    output logic      [15:0] port_data_lines_o,
    output logic             buf_dir_to_bus_o,
    output logic             buf_enable_n_o,
    output logic      [31:0] address_pointer_o,
    output logic      [15:0] host_control_reg_o,
    output logic             loc_wr_req_o,
    output logic             loc_rd_req_o,
    output logic      [31:0] loc_addr_o,
    output logic      [15:0] loc_wr_data_o,
    input  wire logic        loc_rd_valid_i,
    input  wire logic [15:0] loc_rd_data_i
);

    pcbhp_bus_s   bus_raw;
    pcbhp_bus_s   bus_meta_r;
    pcbhp_bus_s   bus_sync_r;
    pcbhp_port_s  port_nxt;
    pcbhp_port_s  port_r;
    pcbhp_state_e st_r;
    pcbhp_wr_s    rf_wr;
    logic         in_window;
    logic         strobe_low;
    logic         sel;
    logic         op_ok;
    logic [3:0]   sub;
    pcbhp_fs_e    fs_code;
    logic         lane_hi;
    pcbhp_fs_e    acc_fs_r;
    logic         acc_hi_r;
    logic         acc_wr_r;
    logic         acc_ok_r;
    logic [7:0]   acc_byte_r;
    logic         commit;
    logic         word_done;
    logic [31:0]  ptr_r;
    logic [15:0]  rf_rd_data;
    logic [15:0]  ctrl_word;
    logic [15:0]  rd_word;
    logic         fill_pend_r;
    logic [15:0]  fill_word_r;
    logic         fill_take;

    // Bus pins gathered for the synchroniser
    assign bus_raw = '{addr: bus_addr_i, rd_n: bus_mem_read_n_i,
                       wr_n: bus_mem_write_n_i, dack: bus_dack_i,
                       data: bus_data_i};

    // Two-flop synchroniser, first stage read only by the second
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_meta_r <= '{addr: `PCBHP_ADDR_RST, rd_n: `PCBHP_STB_IDLE,
                            wr_n: `PCBHP_STB_IDLE, dack: `PCBHP_DACK_RST,
                            data: `PCBHP_BYTE_RST};
            bus_sync_r <= '{addr: `PCBHP_ADDR_RST, rd_n: `PCBHP_STB_IDLE,
                            wr_n: `PCBHP_STB_IDLE, dack: `PCBHP_DACK_RST,
                            data: `PCBHP_BYTE_RST};
        end else begin
            bus_meta_r <= bus_raw;
            bus_sync_r <= bus_meta_r;
        end
    end

    // Window decode over address 19..8, strobes and acknowledge
    assign in_window  = bus_sync_r.addr[`PCBHP_WIN_HI:`PCBHP_WIN_LO]
                        == `PCBHP_WIN_TAG;                   // [RULE_08]
    assign strobe_low = !bus_sync_r.rd_n || !bus_sync_r.wr_n;
    assign sel        = in_window && strobe_low
                        && bus_sync_r.dack;            // [RULE_09] [RULE_10]
    assign op_ok      = bus_sync_r.rd_n ^ bus_sync_r.wr_n; // [RULE_12]
    assign sub        = bus_sync_r.addr[`PCBHP_SUB_HI:`PCBHP_SUB_LO];
    assign lane_hi    = bus_sync_r.addr[`PCBHP_LANE_BIT];

    // Sub-range to function code; every other sub-range is data
    always_comb begin
        case (sub)
            `PCBHP_SUB_ALO: fs_code = PCBHP_FS_ALO;          // [RULE_15]
            `PCBHP_SUB_AHI: fs_code = PCBHP_FS_AHI;          // [RULE_11]
            `PCBHP_SUB_CTL: fs_code = PCBHP_FS_CTL;
            default:        fs_code = PCBHP_FS_DATA;         // [RULE_14]
        endcase
    end

    // Port pin values before their buffer stage
    always_comb begin
        port_nxt.cs_n  = !sel;
        port_nxt.uds_n = !lane_hi;                           // [RULE_04]
        port_nxt.lds_n = lane_hi;                            // [RULE_04]
        port_nxt.rd_n  = bus_sync_r.rd_n;                    // [RULE_07]
        port_nxt.wr_n  = bus_sync_r.wr_n;                    // [RULE_07]
        port_nxt.fs    = fs_code;                            // [RULE_11]
    end

    // Buffered host-port control pins
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            port_r <= '{cs_n: `PCBHP_STB_IDLE, uds_n: `PCBHP_STB_IDLE,
                        lds_n: `PCBHP_STB_IDLE, rd_n: `PCBHP_STB_IDLE,
                        wr_n: `PCBHP_STB_IDLE, fs: PCBHP_FS_ALO};
        end else begin
            port_r <= port_nxt;
        end
    end

    assign port_chip_select_n_o  = port_r.cs_n;
    assign upper_byte_strobe_n_o = port_r.uds_n;
    assign lower_byte_strobe_n_o = port_r.lds_n;
    assign port_read_strobe_n_o  = port_r.rd_n;
    assign port_write_strobe_n_o = port_r.wr_n;
    assign function_select_0_o   = port_r.fs[0];
    assign function_select_1_o   = port_r.fs[1];

    // Data buffer control and byte replication
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            buf_dir_to_bus_o  <= 1'b0;
            buf_enable_n_o    <= `PCBHP_STB_IDLE;
            port_data_lines_o <= `PCBHP_WORD_RST;
        end else begin
            buf_dir_to_bus_o  <= !bus_sync_r.rd_n;           // [RULE_06]
            buf_enable_n_o    <= !sel;                       // [RULE_06]
            port_data_lines_o <= {bus_sync_r.data,
                                  bus_sync_r.data};          // [RULE_05]
        end
    end

    // Access sequencer: capture while selected, commit on release
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r       <= PCBHP_ST_IDLE;
            acc_fs_r   <= PCBHP_FS_ALO;
            acc_hi_r   <= 1'b0;
            acc_wr_r   <= 1'b0;
            acc_ok_r   <= 1'b0;
            acc_byte_r <= `PCBHP_BYTE_RST;
        end else begin
            case (st_r)
                PCBHP_ST_IDLE: begin
                    if (sel) begin
                        st_r     <= PCBHP_ST_ACTIVE;
                        acc_fs_r <= fs_code;
                        acc_hi_r <= lane_hi;
                        acc_wr_r <= !bus_sync_r.wr_n;
                        acc_ok_r <= op_ok;                   // [RULE_12]
                    end
                end
                PCBHP_ST_ACTIVE: begin
                    if (sel) begin
                        acc_byte_r <= bus_sync_r.data;
                        acc_ok_r   <= acc_ok_r && op_ok;
                    end else begin
                        st_r <= PCBHP_ST_FINISH;             // [RULE_13]
                    end
                end
                PCBHP_ST_FINISH: st_r <= PCBHP_ST_IDLE;
                default:         st_r <= PCBHP_ST_IDLE;
            endcase
        end
    end

    // At most one commit per access, none if both strobes were low, after chip select has gone high
    assign commit    = (st_r == PCBHP_ST_FINISH) && acc_ok_r;
    assign word_done = commit && acc_hi_r && (acc_fs_r == PCBHP_FS_DATA);

    // Address pointer: byte writes, then step after a data word
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ptr_r <= `PCBHP_PTR_RST;
        end else if (commit && acc_wr_r && acc_fs_r == PCBHP_FS_ALO) begin
            if (acc_hi_r) begin
                ptr_r[15:8] <= acc_byte_r;                   // [RULE_01]
            end else begin
                ptr_r[7:0] <= acc_byte_r;
            end
        end else if (commit && acc_wr_r && acc_fs_r == PCBHP_FS_AHI) begin
            if (acc_hi_r) begin
                ptr_r[31:24] <= acc_byte_r;                  // [RULE_01]
            end else begin
                ptr_r[23:16] <= acc_byte_r;
            end
        end else if (word_done) begin
            ptr_r <= ptr_r + PTR_STEP;                       // [RULE_14]
        end
    end

    assign address_pointer_o = ptr_r;

    // Local read data waits here until the store is free
    assign fill_take = fill_pend_r && !(commit && acc_wr_r);

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fill_pend_r <= 1'b0;
            fill_word_r <= `PCBHP_WORD_RST;
        end else if (loc_rd_valid_i) begin
            fill_pend_r <= 1'b1;
            fill_word_r <= loc_rd_data_i;                    // [RULE_02]
        end else if (fill_take) begin
            fill_pend_r <= 1'b0;
        end
    end

    // Store write: host byte first, local fill otherwise
    always_comb begin
        rf_wr = '{en: 1'b0, idx: `PCBHP_RF_DATA, be: 2'b00,
                  data: `PCBHP_WORD_RST};
        if (commit && acc_wr_r && (acc_fs_r == PCBHP_FS_DATA
                                   || acc_fs_r == PCBHP_FS_CTL)) begin
            rf_wr.en   = 1'b1;
            rf_wr.idx  = (acc_fs_r == PCBHP_FS_CTL);         // [RULE_03]
            rf_wr.be   = {acc_hi_r, !acc_hi_r};              // [RULE_12]
            rf_wr.data = {acc_byte_r, acc_byte_r};
        end else if (fill_take) begin
            rf_wr.en   = 1'b1;
            rf_wr.idx  = `PCBHP_RF_DATA;
            rf_wr.be   = 2'b11;
            rf_wr.data = fill_word_r;                        // [RULE_02]
        end
    end

    pcbhp_regfile #(
        .WORD_W (16)
    ) u_store (
        .mclk_i      (mclk_i),
        .reset_n_i   (reset_n_i),
        .wr_i        (rf_wr),
        .rd_idx_i    (fs_code == PCBHP_FS_CTL),
        .rd_data_o   (rf_rd_data),
        .ctrl_word_o (ctrl_word)
    );

    // Control word to the processor-side functions
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            host_control_reg_o <= `PCBHP_WORD_RST;
        end else begin
            host_control_reg_o <= ctrl_word;                 // [RULE_03]
        end
    end

    // Read word for the selected register
    always_comb begin
        case (acc_fs_r)
            PCBHP_FS_ALO: rd_word = ptr_r[15:0];
            PCBHP_FS_AHI: rd_word = ptr_r[31:16];
            default:      rd_word = rf_rd_data;
        endcase
    end

    // Bus read data: lane picked by the byte strobes
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_data_o    <= `PCBHP_BYTE_RST;
            bus_data_oe_o <= 1'b0;
        end else begin
            bus_data_oe_o <= sel && op_ok && !bus_sync_r.rd_n
                             && (st_r == PCBHP_ST_ACTIVE);   // [RULE_13]
            bus_data_o    <= acc_hi_r ? rd_word[15:8]
                                      : rd_word[7:0];        // [RULE_12]
        end
    end

    // Local bus requests after each completed data-port word
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            loc_wr_req_o  <= 1'b0;
            loc_rd_req_o  <= 1'b0;
            loc_addr_o    <= `PCBHP_PTR_RST;
            loc_wr_data_o <= `PCBHP_WORD_RST;
        end else begin
            loc_wr_req_o <= word_done && acc_wr_r;           // [RULE_02]
            loc_rd_req_o <= word_done && !acc_wr_r;
            if (word_done) begin
                loc_addr_o    <= acc_wr_r ? ptr_r : ptr_r + PTR_STEP;
                loc_wr_data_o <= {acc_byte_r, rf_rd_data[7:0]};
            end
        end
    end

endmodule : pcbhp_bridge

// ### tb/pcbhp_bridge_monitor.sv
// Pin-level checker for the bus to host-port bridge
`timescale 1ns/1ps
module pcbhp_bridge_monitor (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic [19:0] bus_addr_i,
    input  wire logic        bus_mem_read_n_i,
    input  wire logic        bus_mem_write_n_i,
    input  wire logic        bus_dack_i,
    input  wire logic [7:0]  bus_data_i,
    input  wire logic        port_chip_select_n_o,
    input  wire logic        function_select_0_o,
    input  wire logic        function_select_1_o,
    input  wire logic        upper_byte_strobe_n_o,
    input  wire logic        lower_byte_strobe_n_o,
    input  wire logic        port_read_strobe_n_o,
    input  wire logic        port_write_strobe_n_o,
    input  wire logic [15:0] port_data_lines_o,
    input  wire logic        buf_dir_to_bus_o,
    input  wire logic        buf_enable_n_o,
    input  wire logic        loc_wr_req_o
);
    // Function code expected for a sub-range
    function automatic logic [1:0] fs_of(input logic [3:0] s);
        if (s == 4'h0) return 2'h0;
        if (s == 4'h1) return 2'h2;
        if (s == 4'h2) return 2'h3;
        return 2'h1;
    endfunction : fs_of

    // Pins lag the bus by two sync flops and one output flop
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    lane_upper_a: assert property (
        !port_chip_select_n_o |->
        upper_byte_strobe_n_o == !$past(bus_addr_i[0], 3))
        else $error("upper strobe not from address bit zero");
    lane_lower_a: assert property (
        !port_chip_select_n_o |->
        lower_byte_strobe_n_o == $past(bus_addr_i[0], 3))
        else $error("lower strobe not from address bit zero");
    byte_mirror_a: assert property (
        !port_chip_select_n_o && !port_write_strobe_n_o |->
        port_data_lines_o == {2{$past(bus_data_i, 3)}})
        else $error("bus byte not on both port halves");
    buf_enable_a: assert property (
        buf_enable_n_o == port_chip_select_n_o)
        else $error("buffer enable differs from chip select");
    buf_dir_a: assert property (
        !buf_enable_n_o |-> buf_dir_to_bus_o == !$past(bus_mem_read_n_i, 3))
        else $error("buffer direction not from read strobe");
    port_strobe_a: assert property (
        !port_chip_select_n_o |->
        port_read_strobe_n_o == $past(bus_mem_read_n_i, 3) &&
        port_write_strobe_n_o == $past(bus_mem_write_n_i, 3))
        else $error("port strobes do not follow bus strobes");
    select_cause_a: assert property (
        !port_chip_select_n_o |->
        $past(bus_addr_i[19:12], 3) == 8'hC7 && $past(bus_dack_i, 3))
        else $error("chip select outside window");
    select_taken_a: assert property (
        $past(bus_addr_i[19:12], 3) == 8'hC7 && $past(bus_dack_i, 3) &&
        $past(bus_mem_read_n_i, 3) != $past(bus_mem_write_n_i, 3) |->
        !port_chip_select_n_o)
        else $error("window access not selected");
    refresh_block_a: assert property (
        !$past(bus_dack_i, 3) |-> port_chip_select_n_o)
        else $error("refresh cycle selected the port");
    fs_code_a: assert property (
        !port_chip_select_n_o |->
        {function_select_1_o, function_select_0_o} ==
        fs_of($past(bus_addr_i[11:8], 3)))
        else $error("function select wrong for sub-range");
    wr_pulse_a: assert property (
        loc_wr_req_o |=> !loc_wr_req_o)
        else $error("local write request longer than one cycle");

    // Main scenarios reached
    cover property (!port_chip_select_n_o && !port_write_strobe_n_o);
    cover property (!port_chip_select_n_o && !port_read_strobe_n_o);
    cover property (loc_wr_req_o);
endmodule : pcbhp_bridge_monitor

bind pcbhp_bridge pcbhp_bridge_monitor i_mon (.*);

// ### tb/pcbhp_locmem.sv
// Local-bus memory model answering the bridge's requests
`timescale 1ns/1ps
module pcbhp_locmem #(
    parameter int LAT = 3
)(
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic        wr_req_i,
    input  wire logic        rd_req_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [15:0] wr_data_i,
    output logic             rd_valid_o,
    output logic      [15:0] rd_data_o,
    output logic      [31:0] last_wr_addr_o,
    output logic      [15:0] last_wr_data_o,
    output logic      [31:0] last_rd_addr_o
);
    int cnt;

    // Record writes, answer reads LAT cycles after the request
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt            <= 0;
            rd_valid_o     <= 1'b0;
            rd_data_o      <= 16'h0000;
            last_wr_addr_o <= 32'h0000_0000;
            last_wr_data_o <= 16'h0000;
            last_rd_addr_o <= 32'h0000_0000;
        end else begin
            rd_valid_o <= 1'b0;
            rd_data_o  <= ~rd_data_o; // Stale word never held
            if (wr_req_i) begin
                last_wr_addr_o <= addr_i;
                last_wr_data_o <= wr_data_i;
            end
            if (rd_req_i) begin
                last_rd_addr_o <= addr_i;
                cnt            <= LAT;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
            if (!rd_req_i && cnt == 1) begin
                rd_valid_o <= 1'b1;
                rd_data_o  <= last_rd_addr_o[15:0] ^ 16'h5A5A;
            end
        end
    end
endmodule : pcbhp_locmem

// ### tb/tb_top.sv
// Self-checking bench for the bus to host-port bridge
`timescale 1ns/1ps
module tb_top;
    import pcbhp_pkg::*;
    logic        mclk_i    = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [19:0] a         = 20'h0_0000;
    logic        rd_n      = 1'b1;
    logic        wr_n      = 1'b1;
    logic        dk        = 1'b1;
    logic [7:0]  din       = 8'h00;
    logic [7:0]  dout, got;
    logic        oe, cs_n, fs0, fs1, uds_n, lds_n, prd_n, pwr_n, dir, en_n;
    logic        wreq, rreq, rval;
    logic [15:0] pdat, ctl, wdat, rdat, mwd;
    logic [31:0] ptr, laddr, mwa, mra;
    int          errors     = 0;
    int          n_compared = 0;

    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    pcbhp_bridge i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .bus_addr_i(a), .bus_mem_read_n_i(rd_n), .bus_mem_write_n_i(wr_n),
        .bus_dack_i(dk), .bus_data_i(din), .bus_data_o(dout),
        .bus_data_oe_o(oe), .port_chip_select_n_o(cs_n),
        .function_select_0_o(fs0), .function_select_1_o(fs1),
        .upper_byte_strobe_n_o(uds_n), .lower_byte_strobe_n_o(lds_n),
        .port_read_strobe_n_o(prd_n), .port_write_strobe_n_o(pwr_n),
        .port_data_lines_o(pdat), .buf_dir_to_bus_o(dir),
        .buf_enable_n_o(en_n), .address_pointer_o(ptr),
        .host_control_reg_o(ctl), .loc_wr_req_o(wreq), .loc_rd_req_o(rreq),
        .loc_addr_o(laddr), .loc_wr_data_o(wdat),
        .loc_rd_valid_i(rval), .loc_rd_data_i(rdat));

    pcbhp_locmem i_mem (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .wr_req_i(wreq), .rd_req_i(rreq), .addr_i(laddr),
        .wr_data_i(wdat), .rd_valid_o(rval), .rd_data_o(rdat),
        .last_wr_addr_o(mwa), .last_wr_data_o(mwd), .last_rd_addr_o(mra));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    function automatic logic [1:0] exp_fs(input logic [3:0] s);
        if (s == 4'h0) return 2'h0;
        if (s == 4'h1) return 2'h2;
        if (s == 4'h2) return 2'h3;
        return 2'h1;
    endfunction : exp_fs

    // One bus memory cycle with its pin checks, then strobes released
    task automatic acc(input logic [19:0] ad, input logic r, w, k,
                       input logic [7:0] d, output logic [7:0] q);
        logic sel;
        sel = ad[19:12] == 8'hC7 && k && r != w;
        @(posedge mclk_i) #1;
        a    = ad;
        rd_n = r;
        wr_n = w;
        dk   = k;
        din  = w ? ~din : d; // Undriven lines show the inverse
        repeat (8) @(posedge mclk_i);
        #1;
        q = dout;
        if (sel) begin
            chk(cs_n, 1'b0);
            chk({fs1, fs0}, exp_fs(ad[11:8]));
            chk({uds_n, lds_n}, {~ad[0], ad[0]});
            chk({prd_n, pwr_n}, {r, w});
            chk({dir, en_n}, {~r, 1'b0});
            if (!w) chk(pdat, {d, d});
            else chk(oe, 1'b1);
        end else if (r != w) begin
            chk({cs_n, oe}, 2'h2);
        end else begin
            chk(oe, 1'b0);
        end
        @(posedge mclk_i) #1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        din  = ~din;
        repeat (6) @(posedge mclk_i);
    endtask : acc

    task automatic wr(input logic [19:0] ad, input logic [7:0] d);
        logic [7:0] q;
        acc(ad, 1'b1, 1'b0, 1'b1, d, q);
    endtask : wr

    task automatic rdx(input logic [19:0] ad, input logic [7:0] e);
        logic [7:0] q;
        acc(ad, 1'b0, 1'b1, 1'b1, 8'h00, q);
        chk(q, e);
    endtask : rdx

    // Main sequence
    initial begin
        repeat (5) @(posedge mclk_i);
        #1 reset_n_i = 1'b1;
        @(posedge mclk_i) #1;
        chk({cs_n, oe, wreq, rreq}, 4'h8);
        chk({ptr, ctl}, 48'h0000_0000_0000);
        wr(20'hC7000, 8'h34);
        wr(20'hC7001, 8'h12);
        wr(20'hC7100, 8'h78);
        wr(20'hC7101, 8'h56);
        chk(ptr, 32'h5678_1234);
        wr(20'hC7200, 8'hEF);
        wr(20'hC7201, 8'hBE);
        chk(ctl, 16'hBEEF);
        acc(20'hC7200, 1'b1, 1'b0, 1'b0, 8'h00, got);
        acc(20'hC6201, 1'b1, 1'b0, 1'b1, 8'h11, got);
        acc(20'hC7200, 1'b0, 1'b0, 1'b1, 8'h22, got);
        chk(ctl, 16'hBEEF);
        rdx(20'hC7200, 8'hEF);
        rdx(20'hC7201, 8'hBE);
        rdx(20'hC7000, 8'h34);
        rdx(20'hC7101, 8'h56);
        wr(20'hC7300, 8'hAA);
        wr(20'hC7F01, 8'h55);
        chk(mwa, 32'h5678_1234);
        chk(mwd, 16'h55AA);
        chk(ptr, 32'h5678_1244);
        rdx(20'hC7800, 8'hAA);
        rdx(20'hC7801, 8'h55);
        chk(mra, 32'h5678_1254);
        chk(ptr, 32'h5678_1254);
        rdx(20'hC7800, 8'h0E);
        rdx(20'hC7801, 8'h48);
        close_out();
    end

    // Hang guard
    initial begin
        repeat (5000) @(posedge mclk_i);
        errors++;
        close_out();
    end
endmodule : tb_top
